/* File: include/qhb_pkg.sv */
// Package for the quad UART host bus port: constants and types
package qhb_pkg;
  localparam int QHB_DATA_W = 8;
  localparam int QHB_ADDR_W = 3;
  localparam int QHB_CHAN_W = 2;
  localparam int QHB_NUM_CHAN = 4;
  localparam int QHB_NUM_REG = 8;
  // Reset values
  localparam logic [7:0] QHB_DATA_RST = 8'h00;
  localparam logic [2:0] QHB_ADDR_RST = 3'h0;
  localparam logic [1:0] QHB_CHAN_RST = 2'h0;
  localparam logic [3:0] QHB_SEL_RST = 4'hF;
  // Strap level that picks the strobe style bus
  localparam logic QHB_STRAP_STROBE = 1'b1;
  // Direction line levels in read/write style
  localparam logic QHB_DIR_READ = 1'b1;
  localparam logic QHB_DIR_WRITE = 1'b0;
  // Bus cycle state, Gray coded along idle -> read/write -> idle
  typedef enum logic [1:0]
  {
    QHB_IDLE = 2'b00,
    QHB_READ = 2'b01,
    QHB_WRITE = 2'b10
  } qhb_state_e;
endpackage

/* File: core/qhb_port.sv */
// Host bus port of a four-channel UART: pin decode, register access strobes
`timescale 1ns/1ps
// Contract
// - Strap high selects strobe style, low selects read/write style; pins reassigned.
// - Three address lines pick one of eight registers in addressed channel.
// - Eight-bit data bus driven only during reads, sampled during writes.
// - Strobe style: read strobe fall starts read; data driven until rise.
// - Strobe style: write strobe fall begins write; rise loads the byte.
// - Strobe style: exactly one of four chip selects enables its channel.
// - Read/write style: write strobe pin is direction, high read, low write.
// - Read/write style: channel A select is the single chip select.
// - Read/write style: channel B and C selects become channel address lines.
module qhb_port
  import qhb_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic bus_style_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic chan_a_select_n_i,
  input wire logic chan_b_select_n_i,
  input wire logic chan_c_select_n_i,
  input wire logic chan_d_select_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_n_o,
  input wire logic [31:0] rd_data_i,
  output logic rd_req_o,
  output logic wr_req_o,
  output logic [1:0] chan_o,
  output logic [2:0] reg_addr_o,
  output logic [7:0] wr_data_o
);
  // ==========================================================
  // Pin synchronisers: all host pins are asynchronous to clk_i
  localparam int SYNC_W = 20;
  // Reset to idle pin levels; all zeros would look like a selected write
  localparam logic [SYNC_W-1:0] SYNC_RST = {QHB_STRAP_STROBE, 1'b1, 1'b1, QHB_SEL_RST,
    QHB_ADDR_RST, QHB_DATA_RST, 2'h0};
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  wire [SYNC_W-1:0] pins_raw = {bus_style_i, read_strobe_n_i, write_strobe_n_i,
    chan_a_select_n_i, chan_b_select_n_i, chan_c_select_n_i, chan_d_select_n_i,
    addr_i, data_i, 2'h0};
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
    end
    else
    begin
      sync1_reg <= pins_raw;
      sync2_reg <= sync1_reg;
    end
  end
  wire strap_s = sync2_reg[19];
  wire rd_n_s = sync2_reg[18];
  wire wr_n_s = sync2_reg[17];
  wire [3:0] cs_n_s = {sync2_reg[13], sync2_reg[14], sync2_reg[15], sync2_reg[16]};
  wire [2:0] addr_s = sync2_reg[12:10];
  wire [7:0] data_s = sync2_reg[9:2];

  // ==========================================================
  // Style decode
  function automatic logic one_low(input logic [3:0] v);
    one_low = (v == 4'hE) || (v == 4'hD) || (v == 4'hB) || (v == 4'h7);
  endfunction
  function automatic logic [1:0] low_index(input logic [3:0] v);
    low_index = !v[0] ? 2'h0 : !v[1] ? 2'h1 : !v[2] ? 2'h2 : 2'h3;
  endfunction
  wire strobe_style = (strap_s == QHB_STRAP_STROBE);
  // Strobe style: only a single asserted select counts; clashes are ignored
  wire sel_strobe = one_low(cs_n_s);
  wire [1:0] chan_strobe = low_index(cs_n_s);
  wire sel_rw = !cs_n_s[0];
  // Read strobe and channel D select are not looked at in this style
  wire [1:0] chan_rw = {cs_n_s[2], cs_n_s[1]};
  wire selected = strobe_style ? sel_strobe : sel_rw;
  wire [1:0] chan_sel = strobe_style ? chan_strobe : chan_rw;
  // Read/write style: select low qualifies, direction gives read or write
  wire rd_active = selected && (strobe_style ? !rd_n_s : wr_n_s == QHB_DIR_READ);
  wire wr_active = selected && (strobe_style ? (!wr_n_s && rd_n_s)
    : wr_n_s == QHB_DIR_WRITE);

  // ==========================================================
  // Bus cycle state machine
  qhb_state_e state_reg;
  qhb_state_e state_next;
  logic [7:0] latch_reg;
  logic [1:0] chan_reg;
  logic [2:0] addr_reg;
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      QHB_IDLE:
      begin
        if (rd_active)
          state_next = QHB_READ;
        else if (wr_active)
          state_next = QHB_WRITE;
      end
      QHB_READ:
      begin
        if (!rd_active)
          state_next = QHB_IDLE;
      end
      QHB_WRITE:
      begin
        if (!wr_active)
          state_next = QHB_IDLE;
      end
      default: state_next = QHB_IDLE;
    endcase
  end
  wire rd_start = (state_reg == QHB_IDLE) && (state_next == QHB_READ);
  wire wr_end = (state_reg == QHB_WRITE) && (state_next == QHB_IDLE);
  wire [7:0] rd_byte = rd_data_i[8*chan_sel +: 8];
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_reg <= QHB_IDLE;
      latch_reg <= QHB_DATA_RST;
      chan_reg <= QHB_CHAN_RST;
      addr_reg <= QHB_ADDR_RST;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == QHB_IDLE)
      begin
        chan_reg <= chan_sel;
        addr_reg <= addr_s;
      end
      // Sampled all through the write so the rising edge value is kept
      if (state_reg == QHB_WRITE && wr_active)
        latch_reg <= data_s;
    end
  end

  // ==========================================================
  // Output registers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      data_o <= QHB_DATA_RST;
      data_oe_n_o <= 1'b1;
      rd_req_o <= 1'b0;
      wr_req_o <= 1'b0;
      chan_o <= QHB_CHAN_RST;
      reg_addr_o <= QHB_ADDR_RST;
      wr_data_o <= QHB_DATA_RST;
    end
    else
    begin
      rd_req_o <= rd_start;
      wr_req_o <= wr_end;
      if (rd_start || wr_end)
      begin
        chan_o <= rd_start ? chan_sel : chan_reg;
        reg_addr_o <= rd_start ? addr_s : addr_reg;
      end
      if (wr_end)
        wr_data_o <= latch_reg;
      if (rd_start)
        data_o <= rd_byte;
      data_oe_n_o <= !(state_next == QHB_READ);
    end
  end

  // ==========================================================
  // Checks
  read_drive_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rd_start |=> !data_oe_n_o && rd_req_o) else $error("read not driven");
  no_sel_float_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !selected |=> data_oe_n_o) else $error("bus driven unselected");
  write_float_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_reg == QHB_WRITE |-> data_oe_n_o) else $error("bus driven on write");
  write_load_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_end |=> wr_req_o && wr_data_o == $past(latch_reg)) else $error("write lost");
  chan_strobe_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rd_start && strobe_style |=> chan_o == $past(chan_strobe)) else $error("chan bad");
  chan_rw_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rd_start && !strobe_style |=> chan_o == $past(chan_rw)) else $error("rw chan");
  dir_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !strobe_style && sel_rw && wr_n_s && state_reg == QHB_IDLE |=> state_reg == QHB_READ)
    else $error("direction read");
  addr_pass_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    rd_start |=> reg_addr_o == $past(addr_s)) else $error("addr bad");
  rw_select_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !strobe_style && cs_n_s[0] |-> !rd_active && !wr_active) else $error("rw cs");

  // Request pulses last exactly one cycle so the core never acts twice
  sequence read_open_s;
    rd_start;
  endsequence
  sequence read_answer_s;
    rd_req_o && !data_oe_n_o && data_o == $past(rd_byte) ##1 !rd_req_o;
  endsequence
  sequence write_close_s;
    wr_end;
  endsequence
  sequence write_answer_s;
    wr_req_o && data_oe_n_o ##1 !wr_req_o;
  endsequence
  read_pulse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    read_open_s |=> read_answer_s) else $error("read pulse bad");
  write_pulse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    write_close_s |=> write_answer_s) else $error("write pulse bad");
  // Both strobes low with one select: the read is taken, never a write
  clash_read_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    strobe_style && sel_strobe && !rd_n_s && !wr_n_s && state_reg == QHB_IDLE
    |=> state_reg == QHB_READ) else $error("clash not read");
  // Unselected idle stays idle and asks nothing of the core
  idle_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state_reg == QHB_IDLE && !selected
    |=> state_reg == QHB_IDLE && !rd_req_o && !wr_req_o) else $error("idle left");
endmodule

/* File: tb/qhb_core_model.sv */
// Core register model answering reads of the host bus port
`timescale 1ns/1ps
module qhb_core_model
(
  input wire logic [2:0] addr_i,
  output logic [31:0] rd_data_o
);
  // ====
  // Byte per channel and register, distinct so a wrong pick shows
  always_comb
  begin
    for (int n = 0; n < 4; n++)
    begin
      rd_data_o[8*n +: 8] = {n[1:0], 3'h5, addr_i};
    end
  end
endmodule

/* File: tb/qhb_port_tb.sv */
// Testbench for the quad UART host bus port
`timescale 1ns/1ps
module qhb_port_tb;
  import qhb_pkg::*;
  logic clk_i = 0, reset_n_i = 0, sty = 1, rd_n = 1, wr_n = 1;
  logic [3:0] sel_n = 4'hF;
  logic [2:0] addr = 3'h0, reg_addr_o;
  logic [7:0] host_d = 8'h00, data_o, wr_data_o, bus_d;
  logic oe_n, rd_req_o, wr_req_o;
  logic [1:0] chan_o;
  logic [31:0] rd_data;
  int num_errors = 0, checks = 0;
  // ====
  // Wire level; a released host shows the inverse of its last byte
  assign bus_d = !oe_n ? data_o : host_d;
  qhb_port i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_style_i(sty),
    .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .chan_a_select_n_i(sel_n[0]),
    .chan_b_select_n_i(sel_n[1]), .chan_c_select_n_i(sel_n[2]),
    .chan_d_select_n_i(sel_n[3]), .addr_i(addr), .data_i(bus_d), .data_o(data_o),
    .data_oe_n_o(oe_n), .rd_data_i(rd_data), .rd_req_o(rd_req_o), .wr_req_o(wr_req_o),
    .chan_o(chan_o), .reg_addr_o(reg_addr_o), .wr_data_o(wr_data_o));
  qhb_core_model i_core (.addr_i(addr), .rd_data_o(rd_data));
  initial
  begin
    forever #20 clk_i = ~clk_i;
  end
  initial
  begin
    #100000;
    num_errors++;
    give_verdict();
  end
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Bounded wait; a miss is counted as a mismatch
  task automatic wait_for(ref logic s, input logic lvl);
    for (int i = 0; i < 20 && s !== lvl; i++) @(negedge clk_i);
    cmp("wait", lvl, s);
  endtask
  task automatic drive(logic st, logic [1:0] ch, logic [2:0] a, logic act, logic rd);
    @(posedge clk_i);
    sty <= st;
    addr <= a;
    sel_n <= st ? (act ? ~(4'h1 << ch) : 4'hF) : {1'b1, ch, !act};
    rd_n <= st ? !(act && rd) : 1'b1;
    wr_n <= st ? !(act && !rd) : rd;
  endtask
  task automatic xfer(logic st, logic [1:0] ch, logic [2:0] a, logic rd, logic [7:0] d);
    drive(st, ch, a, 1, rd);
    host_d <= rd ? ~host_d : d;
    if (rd)
    begin
      wait_for(oe_n, 0);
      cmp("rdata", {ch, 3'h5, a}, bus_d);
      cmp("rreq", 1, rd_req_o);
      cmp("rchan", ch, chan_o);
      cmp("raddr", a, reg_addr_o);
    end
    else
      repeat (4) @(posedge clk_i);
    drive(st, ch, a, 0, rd);
    if (rd)
      wait_for(oe_n, 1);
    else
    begin
      wait_for(wr_req_o, 1);
      cmp("wdata", d, wr_data_o);
      cmp("wchan", ch, chan_o);
      cmp("waddr", a, reg_addr_o);
    end
    repeat (4) @(posedge clk_i);
  endtask
  task automatic test_style(logic st);
    for (int c = 0; c < 4; c++)
    begin
      xfer(st, c[1:0], 3'(2*c+1), 1, 8'h00);
      xfer(st, c[1:0], 3'(6-2*c), 0, 8'h3C ^ {4{c[1:0]}});
    end
  endtask
  // Both strobes low in strobe style: read is taken, no write follows
  task automatic test_clash();
    @(posedge clk_i);
    sty <= 1'b1;
    addr <= 3'h2;
    sel_n <= 4'hD;
    rd_n <= 1'b0;
    wr_n <= 1'b0;
    wait_for(oe_n, 0);
    cmp("clash_rdata", {2'h1, 3'h5, 3'h2}, bus_d);
    drive(1, 1, 2, 0, 1);
    wait_for(oe_n, 1);
    repeat (6)
    begin
      @(negedge clk_i);
      cmp("clash_wreq", 0, wr_req_o);
    end
  endtask
  // No select, several selects, rw chip select high: all ignored
  task automatic test_idle();
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk_i);
      sty <= i < 2;
      sel_n <= i == 1 ? 4'h0 : 4'hF;
      rd_n <= i == 2;
      wr_n <= 1'b0;
      repeat (6)
      begin
        @(negedge clk_i);
        cmp("idle_oe", 1, oe_n);
        cmp("idle_req", 0, {rd_req_o, wr_req_o});
      end
      drive(1, 0, 0, 0, 1);
      repeat (4) @(posedge clk_i);
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1;
    repeat (2) @(posedge clk_i);
    test_style(1);
    test_style(0);
    test_idle();
    test_clash();
    give_verdict();
  end
endmodule
